/* File: core/fss_core.v */
// fail-safe supervisor: fail-safe mode, forced standby, reset output and watchdog
`timescale 1ns/1ps
`default_nettype none
`include "fss_defs.vh"
module fss_core #(
  parameter [23:0] RST_DLY_CYC = `FSS_RST_DLY_US * `FSS_CLK_MHZ,
  parameter [23:0] LOW_CYC     = `FSS_LOW_MS * `FSS_US_PER_MS * `FSS_CLK_MHZ,
  parameter [23:0] V1OFF_CYC   = `FSS_V1OFF_MS * `FSS_US_PER_MS * `FSS_CLK_MHZ,
  parameter [23:0] WD_P0_CYC   = `FSS_WD_P0_MS * `FSS_US_PER_MS * `FSS_CLK_MHZ,
  parameter [23:0] WD_P1_CYC   = `FSS_WD_P1_MS * `FSS_US_PER_MS * `FSS_CLK_MHZ,
  parameter [23:0] WD_P2_CYC   = `FSS_WD_P2_MS * `FSS_US_PER_MS * `FSS_CLK_MHZ,
  parameter [23:0] WD_P3_CYC   = `FSS_WD_P3_MS * `FSS_US_PER_MS * `FSS_CLK_MHZ
) (
  input  wire        mclk,
  input  wire        reset,
  input  wire        spi_csn,
  input  wire        cmd_kick,
  input  wire        cmd_unlock,
  input  wire        cmd_period_wr,
  input  wire [1:0]  cmd_period_val,
  input  wire        cmd_ctrl_wr,
  input  wire [31:0] cmd_ctrl_data,
  input  wire        cmd_status1_clr,
  input  wire        main_reg_below_fall,
  input  wire        main_reg_above_rise,
  input  wire        thermal_shutdown_level2,
  input  wire        thermal_shutdown_level1,
  input  wire        load_above_thresh,
  input  wire        supply_overvolt,
  input  wire        main_reg_short,
  input  wire        sgnd_lost_in,
  input  wire        wake_can,
  input  wire        wake_lin,
  input  wire        wake_pin,
  input  wire        wake_can_en,
  input  wire        wake_lin_en,
  input  wire        wake_pin_en,
  input  wire        cluster_mode,
  input  wire        standby_req,
  output reg         host_reset_out_o,
  output reg         host_reset_out_oe,
  output reg         main_reg_enable_r,
  output reg         power_outputs_en_r,
  output reg         charge_pump_en_r,
  output reg         safety_lowside_a,
  output reg         safety_lowside_b,
  output reg         lin_tx_enable_r,
  output reg [1:0]   watchdog_period_sel,
  output reg         watchdog_cfg_unlock,
  output reg [31:0]  ctrl_image_r,
  output reg [1:0]   mode_r,
  output reg         failsafe_flag,
  output reg         watchdog_failure_flag,
  output reg [3:0]   watchdog_failure_count,
  output reg         main_reg_undervolt_flag,
  output reg         thermal_sd2_flag,
  output reg         forced_sleep_by_watchdog,
  output reg         forced_sleep_thermal_or_short,
  output reg         signal_ground_lost
);
  localparam [1:0] MD_ACT = 2'h0, MD_STBY = 2'h1, MD_FORCED = 2'h2;
  localparam [1:0] WD_IDLE = 2'h0, WD_LOW = 2'h1, WD_CLOSED = 2'h2, WD_OPEN = 2'h3;
  localparam [1:0] RS_HOLD = 2'h0, RS_DELAY = 2'h1, RS_REL = 2'h2;
  localparam [11:0] UV1_CYC  = `FSS_UV1_US * `FSS_CLK_MHZ;
  localparam [11:0] V1FS_CYC = `FSS_V1FS_US * `FSS_CLK_MHZ;
  localparam [23:0] BLANK_CYC = `FSS_BLANK_US * `FSS_CLK_MHZ;
  localparam NA = 11;
  localparam NC = 39;

  // --------------------------------------------------------------------------
  // synchronisers: monitor, wake and chip-select pins and the command fields, two flops each
  // --------------------------------------------------------------------------
  wire [NA-1:0] async_in = {main_reg_below_fall, main_reg_above_rise, thermal_shutdown_level2,
                            thermal_shutdown_level1, load_above_thresh, supply_overvolt,
                            main_reg_short, sgnd_lost_in, wake_can, wake_lin, wake_pin};
  wire [NC-1:0] cmd_in   = {cmd_kick, cmd_unlock, cmd_period_wr, cmd_period_val,
                            cmd_ctrl_wr, cmd_ctrl_data, cmd_status1_clr};
  reg  [NA-1:0] a_m_r, a_s_r;
  reg  [NC-1:0] c_m_r, c_s_r;
  reg           csn_m_r, csn_s_r, csn_d_r, thermal_shutdown_level2_d_r;

  // fields are stable while chip select is low and just after it rises, so a plain two-flop copy is safe
  always @(posedge mclk) begin
    if (reset) begin
      a_m_r    <= {NA{1'b0}};
      a_s_r    <= {NA{1'b0}};
      c_m_r    <= {NC{1'b0}};
      c_s_r    <= {NC{1'b0}};
      csn_m_r  <= 1'b1;
      csn_s_r  <= 1'b1;
      csn_d_r  <= 1'b1;
      thermal_shutdown_level2_d_r <= 1'b0;
    end else begin
      a_m_r    <= async_in;
      a_s_r    <= a_m_r;
      c_m_r    <= cmd_in;
      c_s_r    <= c_m_r;
      csn_m_r  <= spi_csn;
      csn_s_r  <= csn_m_r;
      csn_d_r  <= csn_s_r;
      thermal_shutdown_level2_d_r <= a_s_r[8];
    end
  end

  wire        below_s = a_s_r[10];
  wire        above_s = a_s_r[9];
  wire        thermal_shutdown_level2_s  = a_s_r[8];
  wire        thermal_shutdown_level1_s  = a_s_r[7];
  wire        load_s  = a_s_r[6];
  wire        ov_s    = a_s_r[5];
  wire        short_s = a_s_r[4];
  wire        gnd_s   = a_s_r[3];
  wire        wake    = (a_s_r[2] & wake_can_en) | (a_s_r[1] & wake_lin_en) | (a_s_r[0] & wake_pin_en);
  wire        frame   = csn_s_r & ~csn_d_r;
  wire        kick    = frame & c_s_r[38];
  wire        st1_clr = frame & c_s_r[0];

  // --------------------------------------------------------------------------
  // timers and state
  // --------------------------------------------------------------------------
  reg  [1:0]  wd_st_r, wd_st_nxt, rs_st_r, rs_st_nxt;
  reg  [11:0] uv_cnt_r;
  reg  [2:0]  tsd_cnt_r;
  reg         fs_r, wd_cause_r, uv_cause_r, pend_r;
  reg         wd_load;
  reg  [23:0] wd_val, wd_half;
  wire        wd_busy, wd_done, rs_busy, rs_done, off_busy, off_done, bl_busy, bl_done;
  wire        v1off_evt, blank_go;

  fss_timer u_wd_tmr (
    .mclk   (mclk),
    .reset  (reset),
    .load   (wd_load),
    .value  (wd_val),
    .busy   (wd_busy),
    .done_r (wd_done)
  );

  fss_timer u_rst_tmr (
    .mclk   (mclk),
    .reset  (reset),
    .load   (rs_st_r == RS_HOLD && rs_st_nxt == RS_DELAY),
    .value  (RST_DLY_CYC),
    .busy   (rs_busy),
    .done_r (rs_done)
  );

  fss_timer u_off_tmr (
    .mclk   (mclk),
    .reset  (reset),
    .load   (v1off_evt),
    .value  (V1OFF_CYC),
    .busy   (off_busy),
    .done_r (off_done)
  );

  fss_timer u_blank_tmr (
    .mclk   (mclk),
    .reset  (reset),
    .load   (blank_go),
    .value  (BLANK_CYC),
    .busy   (bl_busy),
    .done_r (bl_done)
  );

  // --------------------------------------------------------------------------
  // failure events
  // --------------------------------------------------------------------------
  wire active    = (mode_r == MD_ACT) | (mode_r == MD_STBY);
  wire wd_run    = (mode_r == MD_ACT) | ((mode_r == MD_STBY) & load_s);
  wire wd_fail   = wd_run & (wd_st_r != WD_IDLE) &
                   ((kick & (wd_st_r == WD_CLOSED)) |
                    (wd_done & ((wd_st_r == WD_LOW) | (wd_st_r == WD_OPEN))));
  wire uv_rst    = active & below_s & (uv_cnt_r == UV1_CYC - 12'h001);
  wire uv_fs     = active & below_s & (uv_cnt_r == V1FS_CYC - 12'h001);
  wire thermal_shutdown_level2_rise = active & thermal_shutdown_level2_s & ~thermal_shutdown_level2_d_r;
  wire fs_cause  = wd_fail | uv_fs | thermal_shutdown_level2_rise;
  wire wd_forced = wd_fail & (watchdog_failure_count >= `FSS_WDCNT_PRE_MAX);
  wire tsd_forced = thermal_shutdown_level2_rise & (tsd_cnt_r >= `FSS_TSD_PRE_MAX);
  wire hard_fail = wd_forced | tsd_forced | (active & (short_s | gnd_s));
  wire forced_go = (hard_fail | pend_r) & ~ov_s & (mode_r != MD_FORCED);
  wire fs_enter  = ~fs_r & (fs_cause | hard_fail);
  assign v1off_evt = wd_fail & ~wd_forced & (watchdog_failure_count == `FSS_WDCNT_PRE_OFF);
  wire rst_evt   = wd_fail | uv_rst;
  wire wake_go   = (mode_r != MD_ACT) & wake;
  assign blank_go = (mode_r == MD_FORCED) & wake & fs_r;
  wire cause_gone = ~wd_cause_r & ~uv_cause_r & ~thermal_shutdown_level2_s;
  wire fs_exit   = fs_r & st1_clr & cause_gone & ~fs_cause & ~hard_fail;
  wire rs_rel    = (rs_st_r == RS_DELAY) & rs_done & above_s & ~rst_evt;

  // --------------------------------------------------------------------------
  // reset output sequencing
  // --------------------------------------------------------------------------
  always @* begin
    rs_st_nxt = rs_st_r;
    if (rst_evt | forced_go | ~main_reg_enable_r) begin
      rs_st_nxt = RS_HOLD;
    end else begin
      case (rs_st_r)
        RS_HOLD: begin
          if (above_s & (mode_r != MD_FORCED)) begin
            rs_st_nxt = RS_DELAY;
          end
        end
        RS_DELAY: begin
          if (~above_s) begin
            rs_st_nxt = RS_HOLD;
          end else if (rs_done) begin
            rs_st_nxt = RS_REL;
          end
        end
        RS_REL:  rs_st_nxt = RS_REL;
        default: rs_st_nxt = RS_HOLD;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // watchdog window sequencing; the half period is the closed part
  // --------------------------------------------------------------------------
  always @* begin
    case (watchdog_period_sel)
      2'h0:    wd_half = WD_P0_CYC >> 1;
      2'h1:    wd_half = WD_P1_CYC >> 1;
      2'h2:    wd_half = WD_P2_CYC >> 1;
      default: wd_half = WD_P3_CYC >> 1;
    endcase
    wd_st_nxt = wd_st_r;
    wd_load   = 1'b0;
    wd_val    = wd_half;
    if (rst_evt | forced_go) begin
      wd_st_nxt = WD_IDLE;
    end else if (rs_rel) begin
      wd_st_nxt = WD_LOW;
      wd_load   = 1'b1;
      wd_val    = LOW_CYC;
    end else if (wd_run) begin
      case (wd_st_r)
        WD_LOW: begin
          if (kick) begin
            wd_st_nxt = WD_CLOSED;
            wd_load   = 1'b1;
          end
        end
        WD_CLOSED: begin
          if (wd_done) begin
            wd_st_nxt = WD_OPEN;
            wd_load   = 1'b1;
          end
        end
        WD_OPEN: begin
          if (kick) begin
            wd_st_nxt = WD_CLOSED;
            wd_load   = 1'b1;
          end
        end
        default: wd_st_nxt = WD_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // main state, flags and control image
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      mode_r                        <= MD_ACT;
      wd_st_r                       <= WD_IDLE;
      rs_st_r                       <= RS_HOLD;
      uv_cnt_r                      <= 12'h000;
      tsd_cnt_r                     <= 3'h0;
      fs_r                          <= 1'b0;
      wd_cause_r                    <= 1'b0;
      uv_cause_r                    <= 1'b0;
      pend_r                        <= 1'b0;
      host_reset_out_o              <= 1'b0;
      host_reset_out_oe             <= 1'b1;
      main_reg_enable_r             <= 1'b1;
      power_outputs_en_r            <= 1'b0;
      charge_pump_en_r              <= 1'b0;
      safety_lowside_a              <= 1'b0;
      safety_lowside_b              <= 1'b0;
      lin_tx_enable_r               <= 1'b1;
      watchdog_period_sel           <= `FSS_PSEL_POR;
      watchdog_cfg_unlock           <= 1'b0;
      ctrl_image_r                  <= `FSS_CTL_POR;
      failsafe_flag                 <= 1'b0;
      watchdog_failure_flag         <= 1'b0;
      watchdog_failure_count        <= 4'h0;
      main_reg_undervolt_flag       <= 1'b0;
      thermal_sd2_flag              <= 1'b0;
      forced_sleep_by_watchdog      <= 1'b0;
      forced_sleep_thermal_or_short <= 1'b0;
      signal_ground_lost            <= 1'b0;
    end else begin
      wd_st_r <= wd_st_nxt;
      rs_st_r <= rs_st_nxt;
      // reset pin is asserted whenever not released; low level only, pull-up is external
      host_reset_out_oe <= (rs_st_nxt != RS_REL);
      // undervoltage filter saturates so each event fires once per dip
      if (~below_s) begin
        uv_cnt_r <= 12'h000;
      end else if (uv_cnt_r != V1FS_CYC) begin
        uv_cnt_r <= uv_cnt_r + 12'h001;
      end
      // command frame: unlock is one-shot, period write needs the old unlock
      if (frame) begin
        watchdog_cfg_unlock <= c_s_r[37];
        if (watchdog_cfg_unlock & c_s_r[36]) begin
          watchdog_period_sel <= c_s_r[35:34];
        end
        if (c_s_r[33]) begin
          ctrl_image_r <= fs_r ? ((ctrl_image_r & ~`FSS_CTL_FS_OPEN) |
                                  (c_s_r[32:1] & `FSS_CTL_FS_OPEN)) : c_s_r[32:1];
        end
      end
      // failure counters, saturating
      if (wd_fail) begin
        if (watchdog_failure_count != `FSS_WDCNT_MAX) begin
          watchdog_failure_count <= watchdog_failure_count + 4'h1;
        end
      end else if (kick & (wd_st_r == WD_OPEN)) begin
        watchdog_failure_count <= 4'h0;
      end
      if (thermal_shutdown_level2_rise & (tsd_cnt_r != `FSS_TSD_MAX)) begin
        tsd_cnt_r <= tsd_cnt_r + 3'h1;
      end
      // causes: set wins over the clearing condition
      if (wd_fail) begin
        wd_cause_r <= 1'b1;
      end else if (kick & (wd_st_r == WD_LOW)) begin
        wd_cause_r <= 1'b0;
      end
      if (uv_fs) begin
        uv_cause_r <= 1'b1;
      end else if (above_s) begin
        uv_cause_r <= 1'b0;
      end
      // status one flags: set wins over read and clear
      watchdog_failure_flag   <= wd_fail | (watchdog_failure_flag & ~st1_clr);
      main_reg_undervolt_flag <= uv_fs | (main_reg_undervolt_flag & ~st1_clr);
      thermal_sd2_flag        <= thermal_shutdown_level2_rise | (thermal_sd2_flag & ~st1_clr);
      forced_sleep_by_watchdog <= wd_forced | (forced_sleep_by_watchdog & ~st1_clr);
      forced_sleep_thermal_or_short <= tsd_forced | (active & short_s) |
                                       (forced_sleep_thermal_or_short & ~st1_clr);
      signal_ground_lost      <= (active & gnd_s) | (signal_ground_lost & ~st1_clr);
      // fail-safe state
      if (fs_cause | hard_fail) begin
        fs_r          <= 1'b1;
        failsafe_flag <= 1'b1;
      end else if (fs_exit) begin
        fs_r          <= 1'b0;
        failsafe_flag <= 1'b0;
      end
      if (fs_enter & ~forced_go) begin
        ctrl_image_r <= `FSS_CTL_FSDEF | (ctrl_image_r & `FSS_CTL_GEN_MASK);
      end
      // overvoltage keeps the device in temporary fail-safe until it clears
      if (forced_go) begin
        pend_r <= 1'b0;
      end else if (hard_fail & ov_s) begin
        pend_r <= 1'b1;
      end
      // operating mode and regulator
      if (forced_go) begin
        mode_r              <= MD_FORCED;
        main_reg_enable_r   <= 1'b0;
        ctrl_image_r        <= `FSS_CTL_POR;
        watchdog_period_sel <= `FSS_PSEL_POR;
        watchdog_cfg_unlock <= 1'b0;
      end else if (wake_go) begin
        mode_r            <= MD_ACT;
        main_reg_enable_r <= 1'b1;
      end else if ((mode_r == MD_ACT) & standby_req) begin
        mode_r <= MD_STBY;
      end else if (v1off_evt) begin
        main_reg_enable_r <= 1'b0;
      end else if (off_done & (mode_r != MD_FORCED)) begin
        main_reg_enable_r <= 1'b1;
      end
      // drivers: fail-safe forces outputs off and the safety low-sides on, except during the wake blanking time
      power_outputs_en_r <= ctrl_image_r[`FSS_CTL_OUT_BIT] & ~fs_r & (mode_r == MD_ACT);
      charge_pump_en_r   <= ctrl_image_r[`FSS_CTL_CP_BIT] & ~fs_r & (mode_r == MD_ACT);
      safety_lowside_a   <= fs_r & ~bl_busy & ~blank_go;
      safety_lowside_b   <= fs_r & ~bl_busy & ~blank_go;
      lin_tx_enable_r    <= ~(fs_r & cluster_mode & thermal_shutdown_level1_s);
    end
  end
endmodule
`default_nettype wire

/* File: core/fss_timer.v */
// one-shot down counter giving a busy level and a done pulse
`timescale 1ns/1ps
`default_nettype none
module fss_timer (
  input  wire        mclk,
  input  wire        reset,
  input  wire        load,
  input  wire [23:0] value,
  output wire        busy,
  output reg         done_r
);
  reg [23:0] cnt_r;

  // --------------------------------------------------------------------------
  // count down; a new load restarts the count at once
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      cnt_r  <= 24'h00_0000;
      done_r <= 1'b0;
    end else if (load) begin
      cnt_r  <= value;
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == 24'h00_0001);
      if (cnt_r != 24'h00_0000) begin
        cnt_r <= cnt_r - 24'h00_0001;
      end
    end
  end

  assign busy = (cnt_r != 24'h00_0000);
endmodule
`default_nettype wire

/* File: inc/fss_defs.vh */
// constants for the fail-safe supervisor: timing, counts and control image layout
`ifndef FSS_DEFS_VH
`define FSS_DEFS_VH

// --------------------------------------------------------------------------
// time base
// --------------------------------------------------------------------------
`define FSS_CLK_MHZ        40
`define FSS_BLANK_US       25
`define FSS_UV1_US         16
`define FSS_V1FS_US        24
`define FSS_RST_DLY_US     1000
`define FSS_LOW_MS         200
`define FSS_V1OFF_MS       200
`define FSS_WD_P0_MS       10
`define FSS_WD_P1_MS       20
`define FSS_WD_P2_MS       50
`define FSS_WD_P3_MS       100
`define FSS_US_PER_MS      1000

// --------------------------------------------------------------------------
// failure counts
// --------------------------------------------------------------------------
`define FSS_WDCNT_MAX      4'hF
`define FSS_WDCNT_PRE_MAX  4'hE
`define FSS_WDCNT_PRE_OFF  4'h7
`define FSS_TSD_MAX        3'h7
`define FSS_TSD_PRE_MAX    3'h6

// --------------------------------------------------------------------------
// control image layout and defaults
// --------------------------------------------------------------------------
`define FSS_CTL_TRACK_LSB  0
`define FSS_CTL_CAN_BIT    2
`define FSS_CTL_CYC_LSB    3
`define FSS_CTL_PWMF_LSB   7
`define FSS_CTL_DUTY_LSB   10
`define FSS_CTL_TIMER_LSB  20
`define FSS_CTL_GEN_BIT    28
`define FSS_CTL_OUT_BIT    29
`define FSS_CTL_CP_BIT     30
`define FSS_CTL_FS_OPEN    32'h0FFF_FFFF
`define FSS_CTL_GEN_MASK   32'h1000_0000
`define FSS_CTL_POR        32'h0000_0000
`define FSS_CTL_FSDEF      32'h0000_0000
`define FSS_PSEL_POR       2'h0

`endif

/* File: test/fss_core_properties.sv */
// port-level assertions for the fail-safe supervisor
`timescale 1ns/1ps
`default_nettype none
module fss_core_properties (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        host_reset_out_oe,
  input wire logic        main_reg_enable_r,
  input wire logic        power_outputs_en_r,
  input wire logic        charge_pump_en_r,
  input wire logic        safety_lowside_a,
  input wire logic        failsafe_flag,
  input wire logic        watchdog_failure_flag,
  input wire logic [3:0]  watchdog_failure_count,
  input wire logic [1:0]  mode_r,
  input wire logic [31:0] ctrl_image_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // pin stays asserted a while after the regulator returns; uc must not start on a rising rail
  sequence s_pin_held;
    host_reset_out_oe [*8];
  endsequence
  AST_LOWSIDE: assert property ($rose(failsafe_flag) |-> ##[0:2] safety_lowside_a) else $error("lowside off");
  AST_OUTS: assert property (failsafe_flag && $past(failsafe_flag) |-> !power_outputs_en_r && !charge_pump_en_r)
    else $error("outputs on");
  AST_WDRST: assert property ($rose(watchdog_failure_flag) |-> ##[0:2] host_reset_out_oe) else $error("no pulse");
  AST_CNTSAT: assert property (watchdog_failure_count == 4'hF |=> watchdog_failure_count inside {4'hF, 4'h0})
    else $error("count wrapped");
  AST_FORCED: assert property (mode_r == 2'h2 && $past(mode_r) == 2'h2 |-> !main_reg_enable_r && ctrl_image_r == 32'h0)
    else $error("forced state");
  AST_FSCTL: assert property (failsafe_flag && $past(failsafe_flag) |-> ctrl_image_r[31:29] == 3'h0)
    else $error("ctrl in fs");
  AST_RELEASE: assert property ($fell(host_reset_out_oe) |-> main_reg_enable_r && mode_r != 2'h2)
    else $error("early release");
  AST_RSTDLY: assert property ($rose(main_reg_enable_r) |-> s_pin_held) else $error("short hold");
endmodule
bind fss_core fss_core_properties i_props (.*);
`default_nettype wire

/* File: test/fss_core_tb_top.sv */
// self-checking bench for the fail-safe supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
`define WT(c) for (int n = 0; n < 20000 && !(c); n++) @(negedge mclk);
module fss_core_tb_top;
  logic mclk, reset, spi_csn, cmd_kick, cmd_unlock, cmd_period_wr, cmd_status1_clr, cmd_ctrl_wr;
  logic main_reg_below_fall, main_reg_above_rise, thermal_shutdown_level2, thermal_shutdown_level1;
  logic load_above_thresh, supply_overvolt, main_reg_short, sgnd_lost_in, wake_can, wake_lin, wake_pin;
  logic wake_can_en, wake_lin_en, wake_pin_en, cluster_mode, standby_req, host_reset_out_o, host_reset_out_oe;
  logic main_reg_enable_r, power_outputs_en_r, charge_pump_en_r, safety_lowside_a, safety_lowside_b;
  logic lin_tx_enable_r, watchdog_cfg_unlock, failsafe_flag, watchdog_failure_flag, main_reg_undervolt_flag;
  logic thermal_sd2_flag, forced_sleep_by_watchdog, forced_sleep_thermal_or_short, signal_ground_lost;
  logic [1:0] cmd_period_val, watchdog_period_sel, mode_r;
  logic [3:0] watchdog_failure_count;
  logic [31:0] cmd_ctrl_data, ctrl_image_r;
  int fails, tests_run, cyc;
  // short counts keep the run to a few thousand cycles
  fss_core #(.RST_DLY_CYC(24'd20), .LOW_CYC(24'd200), .V1OFF_CYC(24'd50), .WD_P0_CYC(24'd40), .WD_P1_CYC(24'd80),
    .WD_P2_CYC(24'd120), .WD_P3_CYC(24'd160)) i_dut (.*);
  fss_host_model i_host (.*);
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // reset pin holds for the full delay after the rail is good
  task automatic t_boot();
    int k = 0;
    @(posedge mclk) main_reg_above_rise <= 1'b1;
    while (host_reset_out_oe && k < 200) begin @(negedge mclk); k++; end
    `CHK(k >= 20, 1'b1)
    `CHK(host_reset_out_oe, 1'b0)
  endtask
  // period write only in the frame straight after unlock
  task automatic t_cfg();
    i_host.frame(6'h10);
    `CHK(watchdog_cfg_unlock, 1'b1)
    i_host.frame(6'h0E);
    `CHK({watchdog_period_sel, watchdog_cfg_unlock}, 3'h6)
    i_host.frame(6'h0A);
    `CHK(watchdog_period_sel, 2'h3)
  endtask
  // control write in active mode drives outputs; cluster thermal stage primed for fail-safe
  task automatic t_ctrl();
    @(posedge mclk) {cmd_ctrl_wr, cmd_ctrl_data, cluster_mode, thermal_shutdown_level1} <= {1'b1, 32'h7000_0001, 2'h3};
    i_host.frame(6'h00);
    `CHK(ctrl_image_r, 32'h7000_0001)
    `CHK({power_outputs_en_r, charge_pump_en_r, lin_tx_enable_r}, 3'h7)
    @(posedge mclk) cmd_ctrl_wr <= 1'b0;
  endtask
  // missed long window: fail-safe entry, then kick and read-clear to leave
  task automatic t_watchdog_failure_flag();
    `WT(watchdog_failure_flag)
    repeat (2) @(negedge mclk);
    `CHK({failsafe_flag, watchdog_failure_count}, 5'h11)
    `CHK({safety_lowside_a, safety_lowside_b, power_outputs_en_r, host_reset_out_oe}, 4'hD)
    `CHK(ctrl_image_r, 32'h1000_0000)
    `CHK(lin_tx_enable_r, 1'b0)
    `WT(!host_reset_out_oe)
    @(posedge mclk) {cmd_ctrl_wr, cmd_ctrl_data} <= {1'b1, 32'hE000_0005};
    i_host.frame(6'h20);
    i_host.frame(6'h01);
    `CHK(failsafe_flag, 1'b0)
    `CHK(ctrl_image_r, 32'h1000_0005)
    @(posedge mclk) cmd_ctrl_wr <= 1'b0;
  endtask
  // undervolt: read-clear drops the flag, but fail-safe holds while the rail is still low
  task automatic t_uv();
    @(posedge mclk) {main_reg_below_fall, main_reg_above_rise} <= 2'h2;
    `WT(main_reg_undervolt_flag)
    i_host.frame(6'h01);
    `CHK({main_reg_undervolt_flag, failsafe_flag}, 2'h1)
    @(posedge mclk) {main_reg_below_fall, main_reg_above_rise} <= 2'h1;
  endtask
  // no kicks: 15 failures force standby, an enabled wake pin ends it
  task automatic t_forced();
    `WT(mode_r == 2'h2)
    `CHK({forced_sleep_by_watchdog, watchdog_failure_count, main_reg_enable_r}, 6'h3E)
    @(posedge mclk) {wake_pin_en, wake_pin} <= 2'h3;
    `WT(mode_r == 2'h0)
    repeat (5) @(negedge mclk);
    `CHK({main_reg_enable_r, safety_lowside_a, failsafe_flag}, 3'h5)
  endtask
  // ground loss under overvoltage: flags at once, forced standby once it clears, can wake
  task automatic t_gnd();
    @(posedge mclk) {wake_pin, supply_overvolt, sgnd_lost_in, thermal_shutdown_level2} <= 4'h7;
    repeat (6) @(negedge mclk);
    `CHK({signal_ground_lost, thermal_sd2_flag, mode_r}, 4'hC)
    @(posedge mclk) {supply_overvolt, sgnd_lost_in, thermal_shutdown_level2} <= 3'h0;
    `WT(mode_r == 2'h2)
    `CHK({mode_r, main_reg_enable_r}, 3'h4)
    @(posedge mclk) {wake_can_en, wake_can} <= 2'h3;
    `WT(mode_r == 2'h0)
    `CHK({mode_r, main_reg_enable_r}, 3'h1)
  endtask
  initial begin
    {cmd_ctrl_wr, cmd_ctrl_data, main_reg_below_fall, main_reg_above_rise, thermal_shutdown_level2} = '0;
    {thermal_shutdown_level1, load_above_thresh, supply_overvolt, main_reg_short, sgnd_lost_in} = '0;
    {wake_can, wake_lin, wake_pin, wake_can_en, wake_lin_en, wake_pin_en, cluster_mode, standby_req} = '0;
    {fails, tests_run, cyc} = '0;
    reset = 1'b1;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    t_boot();
    t_cfg();
    t_ctrl();
    t_watchdog_failure_flag();
    t_uv();
    t_forced();
    t_gnd();
    results();
  end
endmodule
`default_nettype wire

/* File: test/fss_host_model.sv */
// host microcontroller model issuing command frames
`timescale 1ns/1ps
`default_nettype none
module fss_host_model (
  input  wire logic       mclk,
  output var  logic       spi_csn,
  output var  logic       cmd_kick,
  output var  logic       cmd_unlock,
  output var  logic       cmd_period_wr,
  output var  logic [1:0] cmd_period_val,
  output var  logic       cmd_status1_clr
);
  // idle: deselected, no command
  initial begin
    spi_csn = 1'b1;
    {cmd_kick, cmd_unlock, cmd_period_wr, cmd_period_val, cmd_status1_clr} = 6'h00;
  end
  // whole frame; fields held past csn rise so the synced sample sees them
  task automatic frame(input logic [5:0] f);
    @(posedge mclk);
    {cmd_kick, cmd_unlock, cmd_period_wr, cmd_period_val, cmd_status1_clr} <= f;
    spi_csn <= 1'b0;
    repeat (4) @(posedge mclk);
    spi_csn <= 1'b1;
    repeat (6) @(posedge mclk);
    {cmd_kick, cmd_unlock, cmd_period_wr, cmd_period_val, cmd_status1_clr} <= 6'h00;
  endtask
endmodule
`default_nettype wire
